/* File: src/aao_pkg.sv */
// shared constants and types of the arithmetic and logic datapath
package aao_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TGT_LO = 8'h04;
  localparam logic [7:0] ADDR_TGT_HI = 8'h08;
  localparam logic [7:0] ADDR_SRC = 8'h0c;
  localparam logic [7:0] ADDR_IMM = 8'h10;
  localparam logic [7:0] ADDR_SREG = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_IOSEL = 8'h1c;
  localparam logic [7:0] ADDR_IODAT = 8'h20;
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int CTRL_OP_W = 5;
  localparam int CTRL_GO_BIT = 7;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [7:0] MASK_ARITH = 8'h2f;
  localparam logic [7:0] MASK_LOGIC = 8'h0e;
  localparam logic [7:0] MASK_INVERT = 8'h0f;
  localparam logic [7:0] MASK_WORD = 8'h1f;
  localparam int WORD_IMM_W = 6;
  localparam int IO_AW = 6;
  localparam logic [IO_AW-1:0] IO_BIT_TOP = 6'h1f;
  localparam logic [IO_AW-1:0] IO_FLAG_IDX = 6'h0e;
  localparam logic [7:0] ALL_ONES = 8'hff;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] SREG_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] FLAG_W1C_RST = 8'hf0;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [CTRL_OP_W-1:0] {
    OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_DIFF_CARRY, OP_IMM_DIFF, OP_IMM_DIFF_CARRY,
    OP_WORD_SUM, OP_WORD_DIFF, OP_CONJ, OP_IMM_CONJ, OP_DISJ, OP_IMM_DISJ,
    OP_XDISJ, OP_INVERT, OP_ARITH_INV, OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK,
    OP_ZERO_SIGN_CHECK, OP_PLUS_ONE, OP_MINUS_ONE, OP_ZERO_REG, OP_ONES_REG,
    OP_IO_BIT_SET, OP_IO_BIT_CLEAR
  } aao_op_t;
  typedef enum logic [2:0] {K_ADD, K_SUB, K_AND, K_OR, K_XOR, K_COM} aao_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WORD_HI, ST_IO_WRITE} aao_state_t;
endpackage

/* File: src/aao_byte_alu.sv */
// combinational byte ALU producing result and status flags
`timescale 1ns/1ps
module aao_byte_alu import aao_pkg::*; (
  input wire aao_kind_t kind,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  input wire logic keepZ,
  input wire logic zPrev,
  output logic [7:0] res,
  output logic [7:0] flags
);
  logic [8:0] wide;
  logic a7, b7, r7, a3, b3, r3;

  always_comb begin
    wide = 9'h000;
    unique case (kind)
      K_ADD: wide = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
      K_SUB: wide = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};
      K_AND: wide = {1'b0, opA & opB};
      K_OR: wide = {1'b0, opA | opB};
      K_XOR: wide = {1'b0, opA ^ opB};
      K_COM: wide = {1'b0, ALL_ONES - opA};
    endcase
    res = wide[7:0];
    a7 = opA[7];
    b7 = opB[7];
    r7 = res[7];
    a3 = opA[3];
    b3 = opB[3];
    r3 = res[3];
    flags = 8'h00;
    // carry-propagating subtracts keep zero only if it was already set
    flags[FLAG_Z] = (res == 8'h00) & (~keepZ | zPrev);
    flags[FLAG_N] = r7;
    unique case (kind)
      K_ADD: begin
        flags[FLAG_C] = wide[8];
        flags[FLAG_H] = (a3 & b3) | (b3 & ~r3) | (~r3 & a3);
        flags[FLAG_V] = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
      end
      K_SUB: begin
        flags[FLAG_C] = (~a7 & b7) | (b7 & r7) | (r7 & ~a7);
        flags[FLAG_H] = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
        flags[FLAG_V] = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
      end
      K_COM: flags[FLAG_C] = 1'b1;
      default: flags[FLAG_V] = 1'b0;
    endcase
    flags[FLAG_S] = flags[FLAG_N] ^ flags[FLAG_V];
  end
endmodule

/* File: src/aao_datapath.sv */
// arithmetic and logic datapath with wishbone register access and i/o bit bank
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// Operation
// - add source to target, optionally plus carry; flags ZCNVH; one clock.
// - subtract source from target, optionally minus carry; flags ZCNVH; one clock.
// - subtract immediate from target; flags ZCNVH; one clock.
// - subtract immediate and carry from target; flags ZCNVH; one clock.
// - add immediate to 16-bit high:low pair; flags ZCNVS; two clocks.
// - subtract immediate from 16-bit high:low pair; flags ZCNVS; two clocks.
// - AND target with register or immediate; only Z, N, V change; one clock.
// - OR target with register or immediate; only Z, N, V change; one clock.
// - set masked target bits by ORing mask; flags ZNV; one clock.
// - clear masked bits by ANDing with all-ones minus mask; flags ZNV.
// - test register by ANDing with itself, value unchanged, flags ZNV.
// - some status flags clear when a one is written to them.
// - i/o bit set/clear rewrite whole register, clearing flags read as set.
// - i/o bit set/clear only for addresses 0x00 to 0x1f.
module aao_datapath import aao_pkg::*; #(
  parameter logic [7:0] FLAG_W1C_MASK = FLAG_W1C_RST
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] evtSet,
  output logic busy
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  aao_state_t st_r, st_nxt;
  aao_op_t op_r, op_nxt;
  logic [7:0] tgtLo_r, tgtLo_nxt, tgtHi_r, tgtHi_nxt, src_r, src_nxt, imm_r, imm_nxt;
  logic [7:0] sreg_r, sreg_nxt, ioRd_r, ioRd_nxt;
  logic [IO_AW-1:0] ioSel_r, ioSel_nxt;
  logic err_r, err_nxt, carryLo_r, carryLo_nxt, zLo_r, zLo_nxt;
  logic ack_r, ack_nxt, busy_r, busy_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [7:0] ioMem_r [2**IO_AW];
  logic [7:0] ioMem_nxt [2**IO_AW];
  logic busWr, ioWrEn;
  logic [7:0] ioWrData, upd, bitMask;
  aao_kind_t aluKind;
  logic [7:0] aluA, aluB, aluRes, aluFlags;
  logic aluCin, aluKeepZ, aluZPrev;

  assign busWr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
  assign bitMask = 8'h01 << imm_r[2:0];

  aao_byte_alu u_alu (
    .kind(aluKind),
    .opA(aluA),
    .opB(aluB),
    .carryIn(aluCin),
    .keepZ(aluKeepZ),
    .zPrev(aluZPrev),
    .res(aluRes),
    .flags(aluFlags)
  );

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  function automatic logic [7:0] readMux(input logic [7:0] adr);
    unique case (adr)
      ADDR_CTRL: readMux = {3'h0, op_r};
      ADDR_TGT_LO: readMux = tgtLo_r;
      ADDR_TGT_HI: readMux = tgtHi_r;
      ADDR_SRC: readMux = src_r;
      ADDR_IMM: readMux = imm_r;
      ADDR_SREG: readMux = sreg_r;
      ADDR_STAT: readMux = {6'h00, err_r, st_r != ST_IDLE};
      ADDR_IOSEL: readMux = {2'h0, ioSel_r};
      ADDR_IODAT: readMux = ioMem_r[ioSel_r];
      default: readMux = 8'h00;
    endcase
  endfunction

  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    dat_nxt = 32'h0000_0000;
    if (ack_nxt && !wb_we_i) begin
      dat_nxt = {24'h00_0000, readMux(wb_adr_i)};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign busy = busy_r;

  // ----------------------------------------
  // execution
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    tgtLo_nxt = tgtLo_r;
    tgtHi_nxt = tgtHi_r;
    src_nxt = src_r;
    imm_nxt = imm_r;
    sreg_nxt = sreg_r;
    ioSel_nxt = ioSel_r;
    ioRd_nxt = ioRd_r;
    err_nxt = err_r;
    carryLo_nxt = carryLo_r;
    zLo_nxt = zLo_r;
    ioWrEn = 1'b0;
    ioWrData = 8'h00;
    upd = 8'h00;
    aluKind = K_ADD;
    aluA = tgtLo_r;
    aluB = src_r;
    aluCin = 1'b0;
    aluKeepZ = 1'b0;
    aluZPrev = sreg_r[FLAG_Z];
    // bus writes land only while idle; a busy core ignores them
    if (busWr && st_r == ST_IDLE) begin
      unique case (wb_adr_i)
        ADDR_CTRL: begin
          op_nxt = aao_op_t'(wb_dat_i[CTRL_OP_W-1:0]);
          if (wb_dat_i[CTRL_GO_BIT]) begin
            st_nxt = ST_EXEC;
            err_nxt = 1'b0;
          end
        end
        ADDR_TGT_LO: tgtLo_nxt = wb_dat_i[7:0];
        ADDR_TGT_HI: tgtHi_nxt = wb_dat_i[7:0];
        ADDR_SRC: src_nxt = wb_dat_i[7:0];
        ADDR_IMM: imm_nxt = wb_dat_i[7:0];
        ADDR_SREG: sreg_nxt = wb_dat_i[7:0];
        ADDR_IOSEL: ioSel_nxt = wb_dat_i[IO_AW-1:0];
        ADDR_IODAT: begin
          ioWrEn = 1'b1;
          ioWrData = wb_dat_i[7:0];
        end
        default: ;
      endcase
    end
    unique case (st_r)
      ST_IDLE: ;
      ST_EXEC: begin
        st_nxt = ST_IDLE;
        unique case (op_r)
          OP_SUM, OP_SUM_CARRY: begin
            aluCin = (op_r == OP_SUM_CARRY) & sreg_r[FLAG_C];
            upd = MASK_ARITH;
          end
          OP_DIFF, OP_DIFF_CARRY, OP_IMM_DIFF, OP_IMM_DIFF_CARRY: begin
            aluKind = K_SUB;
            aluB = (op_r == OP_IMM_DIFF || op_r == OP_IMM_DIFF_CARRY) ? imm_r : src_r;
            aluCin = (op_r == OP_DIFF_CARRY || op_r == OP_IMM_DIFF_CARRY) & sreg_r[FLAG_C];
            aluKeepZ = op_r == OP_DIFF_CARRY || op_r == OP_IMM_DIFF_CARRY;
            upd = MASK_ARITH;
          end
          OP_WORD_SUM, OP_WORD_DIFF: begin
            aluKind = (op_r == OP_WORD_SUM) ? K_ADD : K_SUB;
            aluB = {2'h0, imm_r[WORD_IMM_W-1:0]};
            carryLo_nxt = aluFlags[FLAG_C];
            zLo_nxt = aluRes == 8'h00;
            st_nxt = ST_WORD_HI;
          end
          OP_CONJ, OP_IMM_CONJ: begin
            aluKind = K_AND;
            aluB = (op_r == OP_IMM_CONJ) ? imm_r : src_r;
            upd = MASK_LOGIC;
          end
          OP_DISJ, OP_IMM_DISJ, OP_BIT_SET_MASK: begin
            aluKind = K_OR;
            aluB = (op_r == OP_DISJ) ? src_r : imm_r;
            upd = MASK_LOGIC;
          end
          OP_XDISJ, OP_ZERO_REG: begin
            aluKind = K_XOR;
            aluB = (op_r == OP_ZERO_REG) ? tgtLo_r : src_r;
            upd = MASK_LOGIC;
          end
          OP_BIT_CLEAR_MASK: begin
            aluKind = K_AND;
            aluB = ALL_ONES - imm_r;
            upd = MASK_LOGIC;
          end
          OP_ZERO_SIGN_CHECK: begin
            aluKind = K_AND;
            aluB = tgtLo_r;
            upd = MASK_LOGIC;
          end
          OP_INVERT: begin
            aluKind = K_COM;
            upd = MASK_INVERT;
          end
          OP_ARITH_INV: begin
            aluKind = K_SUB;
            aluA = 8'h00;
            aluB = tgtLo_r;
            upd = MASK_ARITH;
          end
          OP_PLUS_ONE, OP_MINUS_ONE: begin
            aluKind = (op_r == OP_PLUS_ONE) ? K_ADD : K_SUB;
            aluB = 8'h01;
            upd = MASK_LOGIC;
          end
          OP_ONES_REG: ;
          OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
            // bit instructions reach only the lower half of the i/o space
            if (ioSel_r > IO_BIT_TOP) begin
              err_nxt = 1'b1;
            end else begin
              ioRd_nxt = ioMem_r[ioSel_r];
              st_nxt = ST_IO_WRITE;
            end
          end
          default: err_nxt = 1'b1;
        endcase
        if (op_r == OP_ONES_REG) begin
          tgtLo_nxt = ALL_ONES;
        end else if (op_r != OP_ZERO_SIGN_CHECK && op_r != OP_IO_BIT_SET && op_r != OP_IO_BIT_CLEAR
                     && !err_nxt) begin
          tgtLo_nxt = aluRes;
        end
      end
      ST_WORD_HI: begin
        st_nxt = ST_IDLE;
        aluKind = (op_r == OP_WORD_SUM) ? K_ADD : K_SUB;
        aluA = tgtHi_r;
        aluB = 8'h00;
        aluCin = carryLo_r;
        aluKeepZ = 1'b1;
        aluZPrev = zLo_r;
        tgtHi_nxt = aluRes;
        upd = MASK_WORD;
      end
      ST_IO_WRITE: begin
        st_nxt = ST_IDLE;
        ioWrEn = 1'b1;
        ioWrData = (op_r == OP_IO_BIT_SET) ? (ioRd_r | bitMask) : (ioRd_r & ~bitMask);
      end
    endcase
    sreg_nxt = (sreg_nxt & ~upd) | (aluFlags & upd);
    busy_nxt = st_nxt != ST_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= ST_IDLE;
      op_r <= OP_SUM;
      tgtLo_r <= DATA_RST;
      tgtHi_r <= DATA_RST;
      src_r <= DATA_RST;
      imm_r <= DATA_RST;
      sreg_r <= SREG_RST;
      ioSel_r <= '0;
      ioRd_r <= DATA_RST;
      err_r <= 1'b0;
      carryLo_r <= 1'b0;
      zLo_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      tgtLo_r <= tgtLo_nxt;
      tgtHi_r <= tgtHi_nxt;
      src_r <= src_nxt;
      imm_r <= imm_nxt;
      sreg_r <= sreg_nxt;
      ioSel_r <= ioSel_nxt;
      ioRd_r <= ioRd_nxt;
      err_r <= err_nxt;
      carryLo_r <= carryLo_nxt;
      zLo_r <= zLo_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ----------------------------------------
  // i/o bank with write-one-to-clear flags
  // ----------------------------------------
  always_comb begin
    ioMem_nxt = ioMem_r;
    if (ioWrEn) begin
      if (ioSel_r == IO_FLAG_IDX) begin
        // ones clear flag bits; plain bits store as written
        ioMem_nxt[ioSel_r] = (ioMem_r[ioSel_r] & ~(ioWrData & FLAG_W1C_MASK))
                             | (ioWrData & ~FLAG_W1C_MASK);
      end else begin
        ioMem_nxt[ioSel_r] = ioWrData;
      end
    end
    // a flag event in the clearing cycle survives
    ioMem_nxt[IO_FLAG_IDX] = ioMem_nxt[IO_FLAG_IDX] | (evtSet & FLAG_W1C_MASK);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < 2**IO_AW; i++) begin
        ioMem_r[i] <= DATA_RST;
      end
    end else begin
      ioMem_r <= ioMem_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_sum_value: assert property ((st_r == ST_EXEC && op_r == OP_SUM_CARRY) |=>
    tgtLo_r == 8'($past(tgtLo_r) + $past(src_r) + {7'h00, $past(sreg_r[FLAG_C])}) && st_r == ST_IDLE)
    else $error("sum with carry wrong");
  chk_diff_carry: assert property ((st_r == ST_EXEC && op_r == OP_DIFF_CARRY) |=>
    tgtLo_r == 8'($past(tgtLo_r) - $past(src_r) - {7'h00, $past(sreg_r[FLAG_C])}))
    else $error("difference with carry wrong");
  chk_imm_diff: assert property ((st_r == ST_EXEC && op_r == OP_IMM_DIFF) |=>
    tgtLo_r == 8'($past(tgtLo_r) - $past(imm_r)) && sreg_r[FLAG_C] == ($past(imm_r) > $past(tgtLo_r)))
    else $error("immediate difference wrong");
  chk_imm_diff_c: assert property ((st_r == ST_EXEC && op_r == OP_IMM_DIFF_CARRY) |=>
    tgtLo_r == 8'($past(tgtLo_r) - $past(imm_r) - {7'h00, $past(sreg_r[FLAG_C])}))
    else $error("immediate difference with carry wrong");
  chk_word_sum: assert property ((st_r == ST_EXEC && op_r == OP_WORD_SUM) |=>
    st_r == ST_WORD_HI ##1 (st_r == ST_IDLE
    && {tgtHi_r, tgtLo_r} == 16'($past({tgtHi_r, tgtLo_r}, 2) + {10'h000, $past(imm_r[5:0], 2)})))
    else $error("word sum wrong");
  chk_word_diff: assert property ((st_r == ST_EXEC && op_r == OP_WORD_DIFF) |=>
    ##1 {tgtHi_r, tgtLo_r} == 16'($past({tgtHi_r, tgtLo_r}, 2) - {10'h000, $past(imm_r[5:0], 2)})
    && sreg_r[FLAG_Z] == ({tgtHi_r, tgtLo_r} == 16'h0000))
    else $error("word difference wrong");
  chk_logic_flags: assert property ((st_r == ST_EXEC && (op_r == OP_CONJ || op_r == OP_DISJ)) |=>
    !sreg_r[FLAG_V] && sreg_r[FLAG_C] == $past(sreg_r[FLAG_C]) && sreg_r[FLAG_H] == $past(sreg_r[FLAG_H]))
    else $error("logic op touched carry or half carry");
  chk_set_mask: assert property ((st_r == ST_EXEC && op_r == OP_BIT_SET_MASK) |=>
    tgtLo_r == ($past(tgtLo_r) | $past(imm_r))) else $error("set mask wrong");
  chk_clear_mask: assert property ((st_r == ST_EXEC && op_r == OP_BIT_CLEAR_MASK) |=>
    tgtLo_r == ($past(tgtLo_r) & ~$past(imm_r))) else $error("clear mask wrong");
  chk_check_flags: assert property ((st_r == ST_EXEC && op_r == OP_ZERO_SIGN_CHECK) |=>
    tgtLo_r == $past(tgtLo_r) && sreg_r[FLAG_Z] == (tgtLo_r == 8'h00) && sreg_r[FLAG_N] == tgtLo_r[7])
    else $error("zero sign check wrong");
  chk_w1c_clear: assert property ((ioWrEn && ioSel_r == IO_FLAG_IDX && evtSet == 8'h00) |=>
    (ioMem_r[IO_FLAG_IDX] & $past(ioWrData) & FLAG_W1C_MASK) == 8'h00) else $error("flag not cleared");
  chk_io_rmw: assert property ((st_r == ST_EXEC && op_r == OP_IO_BIT_SET && ioSel_r <= IO_BIT_TOP) |=>
    st_r == ST_IO_WRITE && ioWrEn && ioWrData == ($past(ioMem_r[ioSel_r]) | (8'h01 << imm_r[2:0])))
    else $error("io rewrite wrong");
  chk_io_range: assert property ((st_r == ST_EXEC && op_r inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR}
    && ioSel_r > IO_BIT_TOP) |=> err_r && st_r == ST_IDLE && !ioWrEn) else $error("out of range bit op ran");
  chk_sign_flag: assert property ((st_r == ST_WORD_HI) |=>
    sreg_r[FLAG_S] == (sreg_r[FLAG_N] ^ sreg_r[FLAG_V]) && sreg_r[FLAG_N] == tgtHi_r[7])
    else $error("sign flag wrong");

  cov_word_op: cover property (st_r == ST_EXEC && op_r == OP_WORD_SUM ##2 sreg_r[FLAG_C]);
  cov_io_clear: cover property (st_r == ST_IO_WRITE && op_r == OP_IO_BIT_CLEAR && ioSel_r == IO_FLAG_IDX);
  cov_diff_borrow: cover property (st_r == ST_EXEC && op_r == OP_DIFF_CARRY ##1 sreg_r[FLAG_C]);
endmodule

/* File: tb/aao_host_model.sv */
// bus-master model of the decoder and register-file side of the datapath
`timescale 1ns/1ps
module aao_host_model import aao_pkg::*; (
  input wire logic sysClk,
  input wire logic ack,
  input wire logic [31:0] datR,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] datW,
  output logic [7:0] evtSet
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    datW = 32'h00000000;
    evtSet = 8'h00;
  end

  // ----------------------------------------
  // single classic cycle; waits for ack, only the bench watchdog ends a hang
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    datW <= {24'h000000, d};
    do begin
      @(posedge sysClk);
    end while (ack !== 1'b1);
    q = datR[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sysClk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask

  task automatic pulseEvt(input logic [7:0] v);
    evtSet <= v;
    @(posedge sysClk);
    evtSet <= 8'h00;
    @(posedge sysClk);
  endtask
endmodule

/* File: tb/tb_alu_arith_logic_ops.sv */
// self-checking bench of the arithmetic and logic datapath
`timescale 1ns/1ps
module tb_alu_arith_logic_ops import aao_pkg::*;;
  logic sysClk = 1'b0;
  logic srst = 1'b1;
  logic cyc, stb, we, ack, busy;
  logic [7:0] adr, evtSet;
  logic [3:0] sel;
  logic [31:0] datW, datR;
  int errCount = 0;
  int cmpCount = 0;
  int runLen = 0;
  int lastRun = 0;
  aao_op_t ops[12] = '{OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_DIFF_CARRY, OP_IMM_DIFF, OP_IMM_DIFF_CARRY,
    OP_CONJ, OP_IMM_CONJ, OP_DISJ, OP_IMM_DISJ, OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK};
  // target, source, immediate, flags: overflow, sign edge, borrow to zero with and without old zero
  logic [31:0] vec[5] = '{32'h7f0101c0, 32'h8080ff3f, 32'h100f0f03, 32'h100f0f01, 32'h00000001};
  logic [22:0] wv[3] = '{{1'b0, 16'h7fff, 6'h01}, {1'b1, 16'h0000, 6'h3f}, {1'b1, 16'h0001, 6'h01}};
  // op code, target, source, result, flags; last one is an illegal code that must leave the target
  logic [39:0] xv[8] = '{40'h0d_0f_00_f0_05, 40'h0e_01_00_ff_25, 40'h12_7f_00_80_0c, 40'h13_80_00_7f_08,
    40'h14_5a_00_00_02, 40'h15_00_00_ff_00, 40'h0c_5a_ff_a5_04, 40'h18_33_00_33_00};

  always #10 sysClk = ~sysClk;

  aao_datapath i_aao_datapath (.sys_clk(sysClk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .evtSet(evtSet), .busy(busy));
  aao_host_model i_aao_host_model (.sysClk(sysClk), .ack(ack), .datR(datR), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .datW(datW), .evtSet(evtSet));

  // length of the last busy stretch, in clocks
  always @(posedge sysClk) begin
    if (busy === 1'b1) runLen <= runLen + 1;
    else if (runLen != 0) begin
      lastRun <= runLen;
      runLen <= 0;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finishTest();
    if (errCount == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic runOp(input aao_op_t op, input logic [7:0] d, h, r, k, f);
    logic [7:0] q;
    int n;
    i_aao_host_model.wr(ADDR_TGT_LO, d);
    i_aao_host_model.wr(ADDR_TGT_HI, h);
    i_aao_host_model.wr(ADDR_SRC, r);
    i_aao_host_model.wr(ADDR_IMM, k);
    i_aao_host_model.wr(ADDR_SREG, f);
    i_aao_host_model.wr(ADDR_CTRL, {3'b100, op});
    n = 0;
    do begin
      i_aao_host_model.rd(ADDR_STAT, q);
      n++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 20);
  endtask

  function automatic logic [15:0] refByte(input aao_op_t op, input logic [7:0] d, r, k, f);
    logic [7:0] b, q, s;
    logic cz, ar, sb, zk;
    s = f;
    b = (op inside {OP_IMM_DIFF, OP_IMM_DIFF_CARRY, OP_IMM_CONJ, OP_IMM_DISJ, OP_BIT_SET_MASK,
      OP_BIT_CLEAR_MASK}) ? k : r;
    if (op == OP_ZERO_SIGN_CHECK) b = d;
    zk = op inside {OP_DIFF_CARRY, OP_IMM_DIFF_CARRY};
    cz = (zk || op == OP_SUM_CARRY) ? f[FLAG_C] : 1'b0;
    ar = op inside {OP_SUM, OP_SUM_CARRY};
    sb = op inside {OP_DIFF, OP_DIFF_CARRY, OP_IMM_DIFF, OP_IMM_DIFF_CARRY};
    case (op)
      OP_SUM, OP_SUM_CARRY: q = d + b + cz;
      OP_CONJ, OP_IMM_CONJ, OP_ZERO_SIGN_CHECK: q = d & b;
      OP_DISJ, OP_IMM_DISJ, OP_BIT_SET_MASK: q = d | b;
      OP_BIT_CLEAR_MASK: q = d & (ALL_ONES - b);
      default: q = d - b - cz;
    endcase
    if (ar) begin
      s[FLAG_H] = d[3] & b[3] | b[3] & ~q[3] | ~q[3] & d[3];
      s[FLAG_V] = d[7] & b[7] & ~q[7] | ~d[7] & ~b[7] & q[7];
      s[FLAG_C] = d[7] & b[7] | b[7] & ~q[7] | ~q[7] & d[7];
    end else if (sb) begin
      s[FLAG_H] = ~d[3] & b[3] | b[3] & q[3] | q[3] & ~d[3];
      s[FLAG_V] = d[7] & ~b[7] & ~q[7] | ~d[7] & b[7] & q[7];
      s[FLAG_C] = ~d[7] & b[7] | b[7] & q[7] | q[7] & ~d[7];
    end else s[FLAG_V] = 1'b0;
    s[FLAG_N] = q[7];
    s[FLAG_Z] = (q == 8'h00) && (!zk || f[FLAG_Z]);
    return {q, s};
  endfunction

  function automatic logic [23:0] refWord(input logic isSub, input logic [15:0] w, input logic [5:0] k,
    input logic [7:0] f);
    logic [15:0] q;
    logic [7:0] s;
    s = f;
    q = isSub ? w - k : w + k;
    s[FLAG_V] = isSub ? (w[15] & ~q[15]) : (~w[15] & q[15]);
    s[FLAG_C] = isSub ? (q[15] & ~w[15]) : (~q[15] & w[15]);
    s[FLAG_N] = q[15];
    s[FLAG_Z] = (q == 16'h0000);
    s[FLAG_S] = s[FLAG_N] ^ s[FLAG_V];
    return {q, s};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] q;
    logic [15:0] e;
    logic [23:0] ew;
    repeat (6) @(posedge sysClk);
    srst <= 1'b0;
    @(posedge sysClk);
    i_aao_host_model.rd(ADDR_SREG, q);
    check(q, SREG_RST, "flags after reset");
    i_aao_host_model.rd(ADDR_TGT_LO, q);
    check(q, DATA_RST, "target after reset");
    i_aao_host_model.wr(8'h40, 8'h5a);
    i_aao_host_model.rd(8'h40, q);
    check(q, 8'h00, "unmapped read");
    i_aao_host_model.wr(ADDR_STAT, 8'hff);
    i_aao_host_model.rd(ADDR_STAT, q);
    check(q, 8'h00, "status is read-only");
    foreach (ops[i]) begin
      foreach (vec[j]) begin
        runOp(ops[i], vec[j][31:24], 8'h00, vec[j][23:16], vec[j][15:8], vec[j][7:0]);
        e = refByte(ops[i], vec[j][31:24], vec[j][23:16], vec[j][15:8], vec[j][7:0]);
        i_aao_host_model.rd(ADDR_TGT_LO, q);
        check(q, e[15:8], "byte result");
        i_aao_host_model.rd(ADDR_SREG, q);
        check(q, e[7:0], "byte flags");
        check(8'(lastRun), 8'h01, "byte op length");
      end
    end
    foreach (vec[j]) begin
      runOp(OP_ZERO_SIGN_CHECK, vec[j][31:24], 8'h00, 8'h00, 8'h00, vec[j][7:0]);
      e = refByte(OP_ZERO_SIGN_CHECK, vec[j][31:24], 8'h00, 8'h00, vec[j][7:0]);
      i_aao_host_model.rd(ADDR_TGT_LO, q);
      check(q, vec[j][31:24], "test keeps value");
      i_aao_host_model.rd(ADDR_SREG, q);
      check(q, e[7:0], "test flags");
    end
    foreach (wv[j]) begin
      runOp(wv[j][22] ? OP_WORD_DIFF : OP_WORD_SUM, wv[j][13:6], wv[j][21:14], 8'h00, {2'b00, wv[j][5:0]}, 8'h20);
      ew = refWord(wv[j][22], wv[j][21:6], wv[j][5:0], 8'h20);
      i_aao_host_model.rd(ADDR_TGT_LO, q);
      check(q, ew[15:8], "word low");
      i_aao_host_model.rd(ADDR_TGT_HI, q);
      check(q, ew[23:16], "word high");
      i_aao_host_model.rd(ADDR_SREG, q);
      check(q, ew[7:0], "word flags");
      check(8'(lastRun), 8'h02, "word op length");
    end
    foreach (xv[m]) begin
      runOp(aao_op_t'(xv[m][36:32]), xv[m][31:24], 8'h00, xv[m][23:16], 8'h00, 8'h00);
      i_aao_host_model.rd(ADDR_TGT_LO, q);
      check(q, xv[m][15:8], "other op result");
      i_aao_host_model.rd(ADDR_SREG, q);
      check(q, xv[m][7:0], "other op flags");
      check(8'(lastRun), 8'h01, "other op length");
    end
    // ----------------------------------------
    // i/o bank: clear-on-one flags and bit operations
    // ----------------------------------------
    i_aao_host_model.wr(ADDR_IOSEL, {2'b00, IO_FLAG_IDX});
    i_aao_host_model.wr(ADDR_IODAT, 8'h00);
    i_aao_host_model.pulseEvt(8'hff);
    i_aao_host_model.rd(ADDR_IODAT, q);
    check(q, FLAG_W1C_RST, "flags raised");
    i_aao_host_model.wr(ADDR_IODAT, 8'h10);
    i_aao_host_model.rd(ADDR_IODAT, q);
    check(q, 8'he0, "one clears flag");
    runOp(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    i_aao_host_model.rd(ADDR_IODAT, q);
    check(q, 8'h01, "bit set clears pending flags");
    check(8'(lastRun), 8'h02, "bit op length");
    i_aao_host_model.wr(ADDR_IOSEL, 8'h05);
    i_aao_host_model.wr(ADDR_IODAT, 8'h0a);
    runOp(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    runOp(OP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00);
    i_aao_host_model.rd(ADDR_IODAT, q);
    check(q, 8'h09, "plain entry bit ops");
    i_aao_host_model.wr(ADDR_IOSEL, {2'b00, IO_BIT_TOP});
    i_aao_host_model.wr(ADDR_IODAT, 8'h00);
    runOp(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00);
    i_aao_host_model.rd(ADDR_IODAT, q);
    check(q, 8'h80, "top bit-op address");
    i_aao_host_model.rd(ADDR_STAT, q);
    check(q, 8'h00, "no error at top");
    // entry 0x20 exists in this bank, so writing it stays legal
    i_aao_host_model.wr(ADDR_IOSEL, 8'h20);
    i_aao_host_model.wr(ADDR_IODAT, 8'h00);
    runOp(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    i_aao_host_model.rd(ADDR_STAT, q);
    check(q, 8'h02, "bit op out of range");
    i_aao_host_model.rd(ADDR_IODAT, q);
    check(q, 8'h00, "out of range untouched");
    finishTest();
  end

  // hang guard, well past the few thousand clocks the tests need
  initial begin
    repeat (20000) @(posedge sysClk);
    errCount++;
    finishTest();
  end
endmodule
